/* rtl/flash_pkg.sv */
// Shared constants, types and instruction decode for the flash front end
package flash_pkg;
   // Instruction codes served by the front end
   localparam logic [7:0] OP_READ   = 8'h03;
   localparam logic [7:0] OP_FAST   = 8'h0b;
   localparam logic [7:0] OP_READ4  = 8'h13;
   localparam logic [7:0] OP_DUAL   = 8'hbb;
   localparam logic [7:0] OP_QUAD   = 8'heb;
   localparam logic [7:0] OP_DDRQ   = 8'hed;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_PROG   = 8'h02;
   localparam logic [7:0] OP_WREN   = 8'h06;
   // Mode nibble that keeps continuous read alive
   localparam logic [3:0] CONT_KEY  = 4'ha;
   // Latency cycles per read kind
   localparam logic [3:0] DUMMY_FAST = 4'h8;
   localparam logic [3:0] DUMMY_QUAD = 4'h4;
   localparam logic [3:0] DUMMY_DDR  = 4'h6;
   // Field lengths in bits
   localparam logic [5:0] ABITS_24   = 6'h18;
   localparam logic [5:0] ABITS_32   = 6'h20;
   localparam logic [5:0] INSTR_BITS = 6'h08;
   localparam logic [5:0] MODE_BITS  = 6'h08;
   localparam logic [5:0] BYTE_BITS  = 6'h08;
   // Data direction of a command
   localparam logic [1:0] DIR_NONE  = 2'h0;
   localparam logic [1:0] DIR_READ  = 2'h1;
   localparam logic [1:0] DIR_WRITE = 2'h2;
   localparam logic [1:0] DIR_STAT  = 2'h3;

   // Command phases
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_INSTR = 3'b001,
      ST_ADDR  = 3'b010,
      ST_MODE  = 3'b011,
      ST_DUMMY = 3'b100,
      ST_OUT   = 3'b101,
      ST_IN    = 3'b110,
      ST_DROP  = 3'b111
   } phase_type;

   // Transfer format chosen by an instruction
   typedef struct packed {
      logic       known;
      logic [2:0] width;
      logic       ddr;
      logic [5:0] abits;
      logic       mode;
      logic [3:0] dummy;
      logic [1:0] dir;
   } cmd_info_type;

   // Builds one format entry
   function automatic cmd_info_type info(input logic [2:0] w,
      input logic ddr, input logic [5:0] ab, input logic md,
      input logic [3:0] dm, input logic [1:0] dir);
      info = {1'b1, w, ddr, ab, md, dm, dir};
   endfunction : info

   // Maps an instruction to its transfer format
   function automatic cmd_info_type decode(input logic [7:0] op);
      case (op)
         OP_READ:   decode = info(3'h1, 1'b0, ABITS_24, 1'b0, 4'h0, DIR_READ);
         OP_FAST:   decode = info(3'h1, 1'b0, ABITS_24, 1'b0, DUMMY_FAST,
                                  DIR_READ);
         OP_READ4:  decode = info(3'h1, 1'b0, ABITS_32, 1'b0, 4'h0, DIR_READ);
         OP_DUAL:   decode = info(3'h2, 1'b0, ABITS_24, 1'b1, 4'h0, DIR_READ);
         OP_QUAD:   decode = info(3'h4, 1'b0, ABITS_24, 1'b1, DUMMY_QUAD,
                                  DIR_READ);
         OP_DDRQ:   decode = info(3'h4, 1'b1, ABITS_24, 1'b1, DUMMY_DDR,
                                  DIR_READ);
         OP_STATUS: decode = info(3'h1, 1'b0, 6'h00, 1'b0, 4'h0, DIR_STAT);
         OP_PROG:   decode = info(3'h1, 1'b0, ABITS_24, 1'b0, 4'h0,
                                  DIR_WRITE);
         OP_WREN:   decode = info(3'h1, 1'b0, 6'h00, 1'b0, 4'h0, DIR_NONE);
         default:   decode = '0;
      endcase
   endfunction : decode
endpackage : flash_pkg

/* rtl/pin_events_if.sv */
// Sampled pin events passed from the pin sampler to the command logic
`timescale 1ns/1ps
interface pin_events_if;
   logic       rise;    // Serial clock rising edge seen
   logic       fall;    // Serial clock falling edge seen
   logic       sel;     // Chip select held low
   logic       cs_fall; // Selection begins
   logic       cs_rise; // Selection ends
   logic [3:0] lanes;   // Lane levels aligned to the edges
   modport src (output rise, fall, sel, cs_fall, cs_rise, lanes);
   modport dst (input rise, fall, sel, cs_fall, cs_rise, lanes);
endinterface : pin_events_if

/* rtl/pin_sampler.sv */
// Synchronises the serial pins and turns them into edge pulses
`timescale 1ns/1ps
module pin_sampler #(
   parameter int STAGES = 2
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Raw pins
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] lane_in,
   // Events toward the command logic
   pin_events_if.src       ev
);
   // Refuse a chain too short to settle metastability
   if (STAGES < 2) begin : g_check
      $error("pin_sampler needs at least two stages");
   end

   logic [STAGES-1:0]      sck_s;  // Clock sync chain
   logic [STAGES-1:0]      cs_s;   // Select sync chain
   logic [STAGES-1:0][3:0] ln_s;   // Lane sync chains
   logic                   sck_q;  // Settled clock, one cycle older
   logic                   cs_q;   // Settled select, one cycle older

   // Sync chains; only the last stage is looked at
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sck_s <= '0;
         cs_s  <= '1;
         ln_s  <= '0;
      end else begin
         sck_s <= {sck_s[STAGES-2:0], sck};
         cs_s  <= {cs_s[STAGES-2:0], cs_n};
         ln_s  <= {ln_s[STAGES-2:0], lane_in};
      end
   end

   // Edge detection on settled levels, lanes kept in step
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sck_q      <= 1'b0;
         cs_q       <= 1'b1;
         ev.rise    <= 1'b0;
         ev.fall    <= 1'b0;
         ev.sel     <= 1'b0;
         ev.cs_fall <= 1'b0;
         ev.cs_rise <= 1'b0;
         ev.lanes   <= 4'h0;
      end else begin
         sck_q      <= sck_s[STAGES-1];
         cs_q       <= cs_s[STAGES-1];
         ev.rise    <= sck_s[STAGES-1] & ~sck_q;
         ev.fall    <= ~sck_s[STAGES-1] & sck_q;
         ev.sel     <= ~cs_s[STAGES-1];
         ev.cs_fall <= ~cs_s[STAGES-1] & cs_q;
         ev.cs_rise <= cs_s[STAGES-1] & ~cs_q;
         ev.lanes   <= ln_s[STAGES-1];
      end
   end
endmodule : pin_sampler

/* rtl/spi_flash_command_frontend.sv */
// Device side command front end of a multi-lane serial flash
`timescale 1ns/1ps
module spi_flash_command_frontend #(
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Serial pins; oe high while driving
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic [3:0]  lane_in,
   output logic      [3:0]  lane_out,
   output logic      [3:0]  lane_oe,
   // Configuration levels
   input  wire logic        four_lane_command_mode,
   input  wire logic        quad_enable_bit,
   // Core status
   input  wire logic        busy,
   input  wire logic        op_failed,
   // Read data path
   input  wire logic [7:0]  rd_data,
   output logic             rd_req,
   output logic      [31:0] rd_addr,
   // Write data path
   output logic             wr_valid,
   output logic      [7:0]  wr_data,
   output logic      [31:0] wr_addr,
   // Command execution
   output logic             cmd_exec,
   output logic      [7:0]  cmd_opcode,
   output logic      [31:0] cmd_addr,
   output logic             cont_read
);
   pin_events_if pe ();

   flash_pkg::phase_type    phase;      // Command phase
   flash_pkg::phase_type    next_phase; // Phase after this cycle
   flash_pkg::cmd_info_type info;       // Format of the open command
   flash_pkg::cmd_info_type dinfo;      // Format of incoming opcode
   flash_pkg::cmd_info_type cinfo;      // Format in force right now
   logic [5:0]  cnt;        // Bits or cycles left in the phase
   logic [5:0]  next_cnt;   // Count after this cycle
   logic [31:0] sh;         // Input shift register
   logic [31:0] next_sh;    // Shift register with this capture
   logic [31:0] amask;      // Address cut to its length
   logic [31:0] addr;       // Running write address
   logic [2:0]  bitmod;     // Received bits modulo eight
   logic        armed;      // Falling edge capture allowed
   logic [7:0]  osh;        // Output byte shifter
   logic [3:0]  ocnt;       // Bits left in output byte
   logic [2:0]  w;          // Lane width of the input phase
   logic [2:0]  ow;         // Lane width of read data
   logic        cap;        // Capture one group this cycle
   logic        last;       // This capture ends the field
   logic        deny;       // Instruction refused
   logic        go_dummy;   // Instruction, address or mode done for a read
   logic [5:0]  dcnt;       // Latency count on entry
   logic        drive_ev;   // Drive the next output group
   logic [7:0]  obyte;      // Byte being shifted out
   logic [7:0]  src;        // Fresh byte for output
   logic [7:0]  pv;         // Output group with its enables
   logic        exec_ok;    // Command qualifies for execution

   // Appends one lane group, lane zero as least significant bit
   function automatic logic [31:0] take(input logic [31:0] s,
      input logic [3:0] l, input logic [2:0] wd);
      case (wd)
         3'h2:    take = {s[29:0], l[1:0]};
         3'h4:    take = {s[27:0], l};
         default: take = {s[30:0], l[0]};
      endcase
   endfunction : take

   // Top group of a byte on its lanes, enables above values
   function automatic logic [7:0] put(input logic [7:0] b,
      input logic [2:0] wd);
      case (wd)
         3'h2:    put = {4'h3, 2'b00, b[7:6]};
         3'h4:    put = {4'hf, b[7:4]};
         default: put = {4'h2, 2'b00, b[7], 1'b0};
      endcase
   endfunction : put

   // Pin synchroniser and edge finder
   pin_sampler #(.STAGES(SYNC_STAGES)) u_pins (
      .clk     (clk),
      .reset_n (reset_n),
      .sck     (sck),
      .cs_n    (cs_n),
      .lane_in (lane_in),
      .ev      (pe)
   );

   // Lane widths: four lanes in four lane mode, one lane for the instruction, else from the opcode
   assign w  = (four_lane_command_mode) ? 3'h4 :
               (phase == flash_pkg::ST_INSTR) ? 3'h1 : info.width;
   assign ow = four_lane_command_mode ? 3'h4 : info.width;

   // Captures: rises always, falls only once armed in double rate
   assign cap = pe.sel && (pe.rise || (pe.fall && info.ddr && armed))
             && (phase == flash_pkg::ST_INSTR || phase == flash_pkg::ST_ADDR
             || phase == flash_pkg::ST_MODE || phase == flash_pkg::ST_IN);
   assign last    = cap && (cnt <= {3'h0, w});
   assign next_sh = take(sh, pe.lanes, w);
   assign dinfo   = flash_pkg::decode(next_sh[7:0]);
   assign cinfo   = (phase == flash_pkg::ST_INSTR) ? dinfo : info;
   assign amask   = (cinfo.abits == flash_pkg::ABITS_24) ?
                    {8'h00, next_sh[23:0]} : next_sh;

   // Refusal: unknown, busy other than status, quad without enable
   assign deny = !dinfo.known
              || (busy && dinfo.dir != flash_pkg::DIR_STAT)
              || ((four_lane_command_mode || dinfo.width == 3'h4)
                  && !quad_enable_bit);
   assign dcnt = cinfo.ddr ? {2'b00, cinfo.dummy - 4'h1}
                           : {2'b00, cinfo.dummy};
   assign go_dummy = last && (cinfo.dir == flash_pkg::DIR_READ
                  || cinfo.dir == flash_pkg::DIR_STAT)
                  && ((phase == flash_pkg::ST_MODE)
                  || (phase == flash_pkg::ST_ADDR && !cinfo.mode)
                  || (phase == flash_pkg::ST_INSTR && cinfo.abits == 6'h00
                      && !deny));

   // Output side: first group on the fall that ends latency
   assign drive_ev = pe.sel && ((phase == flash_pkg::ST_OUT
                  && (pe.fall || (info.ddr && pe.rise)))
                  || (phase == flash_pkg::ST_DUMMY && pe.fall
                  && cnt == 6'h00));
   assign src   = (info.dir == flash_pkg::DIR_STAT) ?
                  {6'h00, op_failed, busy} : rd_data;
   assign obyte = (ocnt == 4'h0) ? src : osh;
   assign pv    = put(obyte, ow);
   assign exec_ok = phase == flash_pkg::ST_IN && bitmod == 3'h0
                 && info.dir != flash_pkg::DIR_READ;

   // Next phase and count
   always_comb begin
      next_phase = phase;
      next_cnt   = cnt;
      if (pe.cs_rise) begin
         next_phase = flash_pkg::ST_IDLE;
      end else if (pe.cs_fall) begin
         next_phase = cont_read ? flash_pkg::ST_ADDR
                                : flash_pkg::ST_INSTR;
         next_cnt   = cont_read ? info.abits : flash_pkg::INSTR_BITS;
      end else if (go_dummy) begin
         next_phase = (busy && cinfo.dir == flash_pkg::DIR_READ) ?
                      flash_pkg::ST_DROP : flash_pkg::ST_DUMMY;
         next_cnt   = dcnt;
      end else if (last) begin
         next_cnt = flash_pkg::BYTE_BITS;
         case (phase)
            // Instruction done: pick the next field
            flash_pkg::ST_INSTR: begin
               if (deny) begin
                  next_phase = flash_pkg::ST_DROP;
               end else if (dinfo.abits != 6'h00) begin
                  next_phase = flash_pkg::ST_ADDR;
                  next_cnt   = dinfo.abits;
               end else begin
                  next_phase = flash_pkg::ST_IN;
               end
            end
            // Address done: mode bits or write data
            flash_pkg::ST_ADDR: begin
               next_phase = info.mode ? flash_pkg::ST_MODE
                                      : flash_pkg::ST_IN;
               next_cnt   = flash_pkg::MODE_BITS;
            end
            default: next_phase = phase;
         endcase
      end else if (cap) begin
         next_cnt = cnt - {3'h0, w};
      end else if (phase == flash_pkg::ST_DUMMY && pe.fall && pe.sel) begin
         next_phase = (cnt == 6'h00) ? flash_pkg::ST_OUT : phase;
         next_cnt   = cnt - 6'h01;
      end
   end

   // Phase, count and capture register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= flash_pkg::ST_IDLE;
         cnt   <= 6'h00;
         sh    <= 32'h0;
      end else begin
         phase <= next_phase;
         cnt   <= next_cnt;
         sh    <= cap ? next_sh : sh;
      end
   end

   // Bit count and falling edge arming, cleared per selection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bitmod <= 3'h0;
         armed  <= 1'b0;
      end else if (pe.cs_fall || pe.cs_rise) begin
         bitmod <= 3'h0;
         armed  <= 1'b0;
      end else begin
         bitmod <= cap ? bitmod + w : bitmod;
         armed  <= armed || (cap && pe.rise
                   && phase != flash_pkg::ST_INSTR);
      end
   end

   // Opcode, format and addresses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         info       <= '0;
         cmd_opcode <= 8'h00;
         cmd_addr   <= 32'h0;
         addr       <= 32'h0;
      end else if (last && phase == flash_pkg::ST_INSTR) begin
         info       <= dinfo;
         cmd_opcode <= next_sh[7:0];
      end else if (last && phase == flash_pkg::ST_ADDR) begin
         cmd_addr   <= amask;
         addr       <= amask;
      end else if (wr_valid) begin
         addr       <= addr + 32'h1;
      end
   end

   // Continuous read: mode nibble keeps or ends it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cont_read <= 1'b0;
      end else if (last && phase == flash_pkg::ST_MODE) begin
         cont_read <= next_sh[7:4] == flash_pkg::CONT_KEY;
      end else if (last && phase == flash_pkg::ST_INSTR) begin
         cont_read <= 1'b0;
      end
   end

   // Write bytes and command execution at deselection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_valid <= 1'b0;
         wr_data  <= 8'h00;
         wr_addr  <= 32'h0;
         cmd_exec <= 1'b0;
      end else begin
         wr_valid <= last && phase == flash_pkg::ST_IN
                     && info.dir == flash_pkg::DIR_WRITE;
         wr_data  <= (last && phase == flash_pkg::ST_IN) ?
                     next_sh[7:0] : wr_data;
         wr_addr  <= (last && phase == flash_pkg::ST_IN) ? addr : wr_addr;
         cmd_exec <= pe.cs_rise && exec_ok;
      end
   end

   // Output lanes and read byte requests
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lane_out <= 4'h0;
         lane_oe  <= 4'h0;
         osh      <= 8'h00;
         ocnt     <= 4'h0;
         rd_req   <= 1'b0;
         rd_addr  <= 32'h0;
      end else if (!pe.sel) begin
         lane_oe  <= 4'h0;
         ocnt     <= 4'h0;
         rd_req   <= 1'b0;
      end else if (go_dummy && cinfo.dir == flash_pkg::DIR_READ && !busy) begin
         rd_req   <= 1'b1;
         rd_addr  <= (phase == flash_pkg::ST_ADDR) ? amask : addr;
      end else if (drive_ev) begin
         lane_out <= pv[3:0];
         lane_oe  <= pv[7:4];
         osh      <= obyte << ow;
         ocnt     <= ((ocnt == 4'h0) ? 4'h8 : ocnt) - {1'b0, ow};
         rd_req   <= ocnt == 4'h0 && info.dir == flash_pkg::DIR_READ;
         rd_addr  <= (ocnt == 4'h0) ? rd_addr + 32'h1 : rd_addr;
      end else begin
         rd_req   <= 1'b0;
      end
   end

   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_release;
      !pe.sel ##1 !pe.sel |-> lane_oe == 4'h0;
   endproperty
   a_release: assert property (p_release) else $error("drive while idle");

   property p_latency;
      lane_oe != 4'h0 |-> phase == flash_pkg::ST_OUT;
   endproperty
   a_latency: assert property (p_latency) else $error("early drive");

   property p_first;
      phase == flash_pkg::ST_DUMMY && pe.sel && pe.fall && cnt == 6'h00
         |=> lane_oe != 4'h0;
   endproperty
   a_first: assert property (p_first) else $error("first data late");

   property p_sdr_fall;
      $changed(lane_out) && !info.ddr |-> $past(pe.fall);
   endproperty
   a_sdr_fall: assert property (p_sdr_fall) else $error("bad edge");

   property p_instr;
      pe.cs_fall && !cont_read
         |=> phase == flash_pkg::ST_INSTR && cnt == flash_pkg::INSTR_BITS;
   endproperty
   a_instr: assert property (p_instr) else $error("no instruction");

   property p_cont;
      pe.cs_fall && cont_read |=> phase == flash_pkg::ST_ADDR;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous lost");

   property p_align;
      pe.cs_rise && bitmod != 3'h0 |=> !cmd_exec;
   endproperty
   a_align: assert property (p_align) else $error("unaligned run");

   property p_fresh;
      pe.cs_rise |=> phase == flash_pkg::ST_IDLE ##1 bitmod == 3'h0;
   endproperty
   a_fresh: assert property (p_fresh) else $error("state kept");

   property p_busy;
      phase == flash_pkg::ST_INSTR && last && busy
         && dinfo.dir != flash_pkg::DIR_STAT |=> phase == flash_pkg::ST_DROP;
   endproperty
   a_busy: assert property (p_busy) else $error("busy accepted");

   property p_quad;
      lane_oe[3] |-> quad_enable_bit;
   endproperty
   a_quad: assert property (p_quad) else $error("quad lane drive");

   property p_ddr_instr;
      phase == flash_pkg::ST_INSTR && pe.fall |=> $stable(sh);
   endproperty
   a_ddr_instr: assert property (p_ddr_instr) else $error("fall taken");

   c_exec: cover property (cmd_exec);
   c_cont: cover property (pe.cs_fall && cont_read);
   c_ddr:  cover property (drive_ev && info.ddr && pe.rise);
endmodule : spi_flash_command_frontend

/* test/host_model.sv */
// Bus master model that frames commands on the serial pins
`timescale 1ns/1ps
module host_model (
   // Serial pins toward the device
   output logic       sck,
   output logic       cs_n,
   output logic [3:0] host_lanes,
   // Resolved levels of lanes zero and one
   input  wire logic [1:0] lanes_back
);
   // Idle: deselected, clock parked low, lanes two and three pulled up
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      host_lanes = 4'hc;
   end

   // One frame: nins instruction bits on lane zero, the rest of the ntx
   // bits out and nrx bits back in groups of w lanes, MSB first
   task automatic frame(input logic cpol, input logic [63:0] tx,
      input int ntx, input int nrx, input int nins, input int w,
      output logic [63:0] rx);
      int   k;
      int   g;
      logic sending;
      rx = '0;
      k = ntx;
      sck = cpol;
      #80 cs_n = 1'b0;
      while (k > 0 || nrx > 0) begin
         g = (ntx - k < nins) ? 1 : w;
         sending = k > 0;
         sck = 1'b0;
         // Bits change after the fall, held well past the next rise
         if (sending) begin
            k = k - g;
            host_lanes[1:0] = (g == 2) ? tx[k+:2] : {~tx[k], tx[k]};
         end else begin
            host_lanes[1:0] = ~host_lanes[1:0];
         end
         #80 sck = 1'b1;
         if (!sending) begin
            rx = (g == 2) ? {rx[61:0], lanes_back}
                          : {rx[62:0], lanes_back[1]};
            nrx = nrx - g;
         end
         #80;
      end
      sck = cpol;
      #80 cs_n = 1'b1;
   endtask : frame
endmodule : host_model

/* test/tb_top.sv */
// Self-checking bench for the flash command front end
`timescale 1ns/1ps
module tb_top;
   logic        clk, reset_n, sck, cs_n, rd_req, wr_valid, cmd_exec, cont_read;
   logic        four_lane_command_mode, quad_enable_bit, busy, op_failed;
   logic [3:0]  lane_in, lane_out, lane_oe, host_lanes;
   logic [7:0]  rd_data, wr_data, cmd_opcode;
   logic [31:0] rd_addr, wr_addr, cmd_addr, a;
   logic [63:0] rx;
   logic [39:0] exp_q[$];           // Expected results in arrival order
   logic [15:0] seed = 16'hde6f;    // Random source state
   int          n_fail = 0, total_checks = 0, n_req = 0;

   // Shared lanes: the device wins while it drives
   assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_lanes);

   // Pseudo-random step
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Array byte held at an address
   function automatic logic [7:0] mem(input logic [31:0] x);
      return x[7:0] ^ 8'h5a;
   endfunction : mem
   // Compare and count
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      total_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   endtask : check
   // Verdict and end of run
   task automatic results;
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // Framed read of n bytes from a, then lanes released
   task automatic rd(input logic cpol, input logic [63:0] tx, input int ntx,
      input int n, input int nins, input int w);
      logic [63:0] want;
      want = '0;
      for (int i = 0; i < n; i++) want = {want[55:0], mem(a + i)};
      u_host_model.frame(cpol, tx, ntx, 8 * n, nins, w, rx);
      check(rx[39:0], want[39:0]);
      repeat (8) @(negedge clk);
      check({36'h0, lane_oe}, 40'h0);
   endtask : rd

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   spi_flash_command_frontend u_spi_flash_command_frontend (
      .clk, .reset_n, .sck, .cs_n, .lane_in, .lane_out, .lane_oe,
      .four_lane_command_mode, .quad_enable_bit, .busy, .op_failed,
      .rd_data, .rd_req, .rd_addr, .wr_valid, .wr_data, .wr_addr,
      .cmd_exec, .cmd_opcode, .cmd_addr, .cont_read);
   host_model u_host_model (.sck, .cs_n, .host_lanes,
      .lanes_back(lane_in[1:0]));

   // Core side: serve array bytes, compare results with the notes
   always @(negedge clk) begin
      if (rd_req === 1'b1) begin
         rd_data <= mem(rd_addr);
         n_req++;
      end
      if (exp_q.size() == 0 && (cmd_exec === 1'b1 || wr_valid === 1'b1))
         check({cmd_opcode, wr_addr}, 40'h0);
      else if (cmd_exec === 1'b1)
         check({cmd_opcode, 32'h0}, exp_q.pop_front());
      else if (wr_valid === 1'b1)
         check({wr_data, wr_addr}, exp_q.pop_front());
   end

   // Main sequence
   initial begin
      reset_n = 1'b0;
      {four_lane_command_mode, quad_enable_bit, busy, op_failed} = '0;
      rd_data = 8'h00;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      // Plain and fast reads in both clock modes, then a four-byte address read in mode zero
      for (int m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         a = {8'h00, seed[7:0], seed};
         rd(m[0], {8'h03, a[23:0]}, 32, 3, 8, 1);
         rd(m[0], {8'h0b, a[23:0], 8'h00}, 40, 2, 8, 1);
      end
      a = {seed, ~seed};
      rd(1'b0, {8'h13, a}, 40, 2, 8, 1);
      // Dual read that opens continuous mode, then one with no instruction
      seed = lfsr(seed);
      a = {8'h00, seed, seed[7:0]};
      rd(1'b0, {8'hbb, a[23:0], 8'ha0}, 40, 2, 8, 2);
      check({39'h0, cont_read}, 40'h1);
      a = a + 32'h10;
      rd(1'b0, {a[23:0], 8'h00}, 32, 2, 0, 2);
      check({39'h0, cont_read}, 40'h0);
      // Busy core: status answers, array read dropped
      @(negedge clk);
      busy = 1'b1;
      op_failed = seed[0];
      u_host_model.frame(1'b0, 64'h05, 8, 16, 8, 1, rx);
      check(rx[39:0], {24'h0, {2{6'h0, op_failed, 1'b1}}});
      n_req = 0;
      u_host_model.frame(1'b0, {8'h03, a[23:0]}, 32, 8, 8, 1, rx);
      check(40'(n_req), 40'h0);
      @(negedge clk);
      busy = 1'b0;
      // Quad read without quad enable is refused outright
      u_host_model.frame(1'b0, 64'heb, 8, 16, 8, 1, rx);
      check(40'(n_req), 40'h0);
      // Two-byte write, then one cut mid byte, then standalone ones
      seed = lfsr(seed);
      a = {8'h00, seed, seed[15:8]};
      exp_q.push_back({seed[15:8], a});
      exp_q.push_back({seed[7:0], a + 32'h1});
      exp_q.push_back({8'h02, 32'h0});
      u_host_model.frame(1'b1, {8'h02, a[23:0], seed}, 48, 0, 8, 1,
                         rx);
      check({8'h00, cmd_addr}, {8'h00, a});
      exp_q.push_back({seed[15:8], a});
      u_host_model.frame(1'b0, {8'h02, a[23:0], seed[15:4]}, 44, 0, 8, 1,
                         rx);
      u_host_model.frame(1'b0, {8'h06, 1'b0}, 9, 0, 8, 1, rx);
      exp_q.push_back({8'h06, 32'h0});
      u_host_model.frame(1'b0, 64'h06, 8, 0, 8, 1, rx);
      repeat (8) @(negedge clk);
      check(40'(exp_q.size()), 40'h0);
      results();
   end

   // Watchdog well past the expected run of about 90 us
   initial begin
      #300000;
      n_fail++;
      results();
   end
endmodule : tb_top
